// *** autoneg_next_page_regs.sv ***
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - local Acknowledge2 at bit 12 is writable, resets 0; 1 means can comply.
// - local Toggle bit 11 is read-only, inverse of previous word's toggle.
// - local code bits 10:0 writable; message code if bit 13 set, else unformatted.
// - local code field resets to one, the null message.
// - partner bit 15 reports partner wants more next pages; resets 0.
// - partner bit 14 reports partner acknowledged our word; resets 0.
// - partner bit 13 reports message page versus unformatted; resets 0.
// - partner bit 12 reports partner Acknowledge2; resets 0.
// - partner bit 11 reports received toggle; resets 0.
// - partner code bits 10:0 captured read-only, reset zero.
// - local message page bit 13 writable, resets 1.
// - local next page bit 15 writable, resets 0.
module autoneg_next_page_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // arbitration engine side
   input  wire logic        page_sent,
   input  wire logic        sent_toggle,
   input  wire logic        page_rcvd,
   input  wire logic [15:0] rcvd_page,
   output logic      [15:0] tx_page
);
   // ==========================================================
   // word geometry shared by both next page registers
   localparam int unsigned WORD_W = 16;            // live bits of each register
   localparam int unsigned LANE_W = 8;             // bits behind one write strobe

   // ==========================================================
   // elaboration checks on the shared field map

   // the code field fills every bit up to its msb
   if (np_regs_pkg::CODE_MSB + 1 != np_regs_pkg::CODE_W) begin : g_bad_code_msb
      $error("code field msb and width disagree");
   end

   // the toggle bit sits just above the code field
   if (np_regs_pkg::TOGGLE_BIT != np_regs_pkg::CODE_W) begin : g_bad_toggle_bit
      $error("toggle bit must sit just above the code field");
   end

   // acknowledge2 sits just above the toggle bit
   if (np_regs_pkg::ACK2_BIT != np_regs_pkg::TOGGLE_BIT + 1) begin : g_bad_ack2_bit
      $error("acknowledge2 bit must sit just above the toggle bit");
   end

   // message page sits just above acknowledge2
   if (np_regs_pkg::MP_BIT != np_regs_pkg::ACK2_BIT + 1) begin : g_bad_mp_bit
      $error("message page bit must sit just above acknowledge2");
   end

   // acknowledge sits just above message page
   if (np_regs_pkg::ACK_BIT != np_regs_pkg::MP_BIT + 1) begin : g_bad_ack_bit
      $error("acknowledge bit must sit just above the message page bit");
   end

   // next page is the top bit of the word
   if (np_regs_pkg::NP_BIT != WORD_W - 1) begin : g_bad_np_bit
      $error("next page bit must be the top bit of the word");
   end

   // the lane merge serves exactly two write lanes
   if (WORD_W != 2 * LANE_W) begin : g_bad_lane_count
      $error("word must be exactly two write lanes");
   end

   // the code field crosses the lane edge, so both strobes reach it
   if (np_regs_pkg::CODE_W <= LANE_W) begin : g_bad_lanes
      $error("code field must span both write lanes");
   end

   // the word must fit the 32-bit read data bus
   if (WORD_W > 32) begin : g_bad_word_w
      $error("word is wider than the data bus");
   end

   // the local register needs a word aligned byte address
   if (np_regs_pkg::LOCAL_NP_TX_ADDR % 4 != 0) begin : g_bad_local_addr
      $error("local register address is not word aligned");
   end

   // the partner register needs a word aligned byte address
   if (np_regs_pkg::PARTNER_NP_RX_ADDR % 4 != 0) begin : g_bad_partner_addr
      $error("partner register address is not word aligned");
   end

   // the two registers may not share one address
   if (np_regs_pkg::LOCAL_NP_TX_ADDR == np_regs_pkg::PARTNER_NP_RX_ADDR) begin : g_same_addr
      $error("the two registers share one address");
   end

   // ==========================================================
   // local transmit register fields
   logic                           np_reg;
   logic                           mp_reg;
   logic                           ack2_reg;
   logic                           toggle_reg;
   logic [np_regs_pkg::CODE_W-1:0] code_reg;

   // word views
   logic [WORD_W-1:0]              partner_page;
   logic [WORD_W-1:0]              local_word;
   logic [WORD_W-1:0]              merged_word;

   // bus decode
   logic                           setup;
   logic                           access;
   logic                           rd_setup;
   logic                           wr_local;
   logic                           hit_local;
   logic                           hit_partner;
   logic                           hit_any;

   // ==========================================================
   // helpers

   // compare of the bus address against one register's address
   function automatic logic reg_hit(
      input logic [11:0] addr,
      input logic [11:0] target
   );
      reg_hit = (addr == target);
   endfunction : reg_hit

   // assemble the local word; bit 14 reads as zero
   function automatic logic [15:0] pack_local(
      input logic        np,
      input logic        mp,
      input logic        a2,
      input logic        tg,
      input logic [10:0] code
   );
      pack_local = {np, 1'b0, mp, a2, tg, code};
   endfunction : pack_local

   // lay the enabled write lanes over the current word
   function automatic logic [15:0] lane_merge(
      input logic [15:0] cur,
      input logic [15:0] wdata,
      input logic [1:0]  strb
   );
      lane_merge = cur;
      if (strb[1]) begin
         lane_merge[15:8] = wdata[15:8];
      end
      if (strb[0]) begin
         lane_merge[7:0] = wdata[7:0];
      end
   endfunction : lane_merge

   // read data for the decoded register; the upper half is always zero
   function automatic logic [31:0] read_word(
      input logic        sel_local,
      input logic        sel_partner,
      input logic [15:0] loc,
      input logic [15:0] par
   );
      read_word = 32'h0000_0000;
      if (sel_local) begin
         read_word = {16'h0000, loc};
      end else if (sel_partner) begin
         read_word = {16'h0000, par};
      end
   endfunction : read_word

   // ==========================================================
   // access decode: a setup cycle is answered in the next cycle
   assign setup       = psel && !penable;
   assign access      = psel && penable && pready;
   assign hit_local   = reg_hit(paddr, np_regs_pkg::LOCAL_NP_TX_ADDR);
   assign hit_partner = reg_hit(paddr, np_regs_pkg::PARTNER_NP_RX_ADDR);
   assign hit_any     = hit_local || hit_partner;
   assign rd_setup    = setup && !pwrite;

   // a write lands only at the access edge that sees pready, and only locally
   assign wr_local    = access && pwrite && hit_local;

   // current local word, and the word that a write would leave behind
   assign local_word  = pack_local(np_reg,
                                   mp_reg,
                                   ack2_reg,
                                   toggle_reg,
                                   code_reg);
   assign merged_word = lane_merge(local_word,
                                   pwdata[15:0],
                                   pstrb[1:0]);

   // ==========================================================
   // local fields, one process for each; all but the toggle are writable

   // next page flag, high write lane
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         np_reg <= np_regs_pkg::NP_RST;
      end else if (wr_local) begin
         np_reg <= merged_word[np_regs_pkg::NP_BIT];
      end
   end

   // message page flag, selects how the code field is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mp_reg <= np_regs_pkg::MP_RST;
      end else if (wr_local) begin
         mp_reg <= merged_word[np_regs_pkg::MP_BIT];
      end
   end

   // acknowledge2, set by software when it can comply
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack2_reg <= np_regs_pkg::ACK2_RST;
      end else if (wr_local) begin
         ack2_reg <= merged_word[np_regs_pkg::ACK2_BIT];
      end
   end

   // code field; the two lanes split it at bit 8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_reg <= np_regs_pkg::LOCAL_CODE_RST;
      end else if (wr_local) begin
         code_reg <= merged_word[np_regs_pkg::CODE_MSB:0];
      end
   end

   // toggle follows the engine only: inverse of the last sent word's toggle;
   // software writes to bit 11 never reach it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle_reg <= np_regs_pkg::TOGGLE_RST;
      end else if (page_sent) begin
         toggle_reg <= !sent_toggle;
      end
   end

   // ==========================================================
   // partner page capture, loaded only by the engine
   np_page_capture #(
      .WIDTH (WORD_W)
   ) u_capture (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (page_rcvd),
      .page_in  (rcvd_page),
      .page_out (partner_page)
   );

   // ==========================================================
   // apb answer: one wait-free access phase, unmapped addresses flag an error

   // ready pulses in the access cycle after every setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // error rides with ready for addresses outside the map; nothing else changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && !hit_any;
      end
   end

   // read data stands only beside ready, zero in every other cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= read_word(rd_setup && hit_local,
                             rd_setup && hit_partner,
                             local_word,
                             partner_page);
      end
   end

   // page handed to the arbitration engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_page <= pack_local(np_regs_pkg::NP_RST,
                               np_regs_pkg::MP_RST,
                               np_regs_pkg::ACK2_RST,
                               np_regs_pkg::TOGGLE_RST,
                               np_regs_pkg::LOCAL_CODE_RST);
      end else begin
         tx_page <= local_word;
      end
   end
endmodule : autoneg_next_page_regs

// *** autoneg_next_page_regs_test.sv ***
`timescale 1ns/1ns
module autoneg_next_page_regs_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er_q;
   logic        page_sent, sent_toggle, page_rcvd;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [3:0]  pstrb;
   logic [15:0] rcvd_page, tx_page;
   int          miscompares = 0, tests_run = 0;
   localparam logic [11:0] LOC = np_regs_pkg::LOCAL_NP_TX_ADDR;
   localparam logic [11:0] PAR = np_regs_pkg::PARTNER_NP_RX_ADDR;
   autoneg_next_page_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .page_sent, .sent_toggle, .page_rcvd, .rcvd_page,
      .tx_page);
   np_engine_model i_eng (.pclk, .page_sent, .sent_toggle, .page_rcvd, .rcvd_page);
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   // ==========================================================
   // bus tasks
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      er_q = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      chk("prdata", ex, rd_q);
      chk("pslverr", {31'h0, ee}, {31'h0, er_q});
   endtask : rd
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // ==========================================================
   // tests
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(LOC, 32'h0000_2001, 1'b0);
      rd(PAR, 32'h0000_0000, 1'b0);
      apb(1'b1, LOC, 32'hFFFF_FFFF);
      rd(LOC, 32'h0000_B7FF, 1'b0);
      chk("tx_page", 32'h0000_B7FF, {16'h0000, tx_page});
      pstrb <= 4'h1;
      apb(1'b1, LOC, 32'h0000_0000);
      rd(LOC, 32'h0000_B700, 1'b0);
      pstrb <= 4'hF;
      apb(1'b1, LOC, 32'h0000_0000);
      rd(LOC, 32'h0000_0000, 1'b0);
      i_eng.send(1'b0);
      rd(LOC, 32'h0000_0800, 1'b0);
      apb(1'b1, LOC, 32'h0000_0000);
      rd(LOC, 32'h0000_0800, 1'b0);
      i_eng.send(1'b1);
      rd(LOC, 32'h0000_0000, 1'b0);
      i_eng.recv(16'hF5A5);
      rd(PAR, 32'h0000_F5A5, 1'b0);
      apb(1'b1, PAR, 32'h0000_0000);
      rd(PAR, 32'h0000_F5A5, 1'b0);
      i_eng.recv(16'h0A5A);
      rd(PAR, 32'h0000_0A5A, 1'b0);
      rd(12'h024, 32'h0000_0000, 1'b1);
      // second reset in mid-run with toggle, message page, code and partner word away from their defaults
      i_eng.send(1'b0);
      rd(LOC, 32'h0000_0800, 1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(LOC, 32'h0000_2001, 1'b0);
      rd(PAR, 32'h0000_0000, 1'b0);
      chk("tx_page", 32'h0000_2001, {16'h0000, tx_page});
      print_verdict();
   end
   // hang guard well past the test length
   initial begin
      repeat (2000) @(posedge pclk);
      miscompares++;
      print_verdict();
   end
endmodule : autoneg_next_page_regs_test
bind autoneg_next_page_regs np_regs_checker i_chk (.pclk, .presetn, .psel, .penable, .paddr,
   .prdata, .pready, .pslverr, .page_sent, .sent_toggle, .tx_page);

// *** np_engine_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// arbitration engine stand-in: one-cycle page pulses
module np_engine_model (
   input  wire logic        pclk,
   output logic             page_sent,
   output logic             sent_toggle,
   output logic             page_rcvd,
   output logic      [15:0] rcvd_page
);
   initial {page_sent, sent_toggle, page_rcvd, rcvd_page} = '0;
   // data is hidden by its inverse once the pulse ends
   task automatic recv(input logic [15:0] pg);
      {page_rcvd, rcvd_page} <= {1'b1, pg};
      @(posedge pclk);
      {page_rcvd, rcvd_page} <= {1'b0, ~pg};
   endtask : recv
   task automatic send(input logic tg);
      {page_sent, sent_toggle} <= {1'b1, tg};
      @(posedge pclk);
      {page_sent, sent_toggle} <= {1'b0, ~tg};
   endtask : send
endmodule : np_engine_model

// *** np_page_capture.sv ***
`timescale 1ns/1ns
// ==========================================================
// holds the last next page received from the partner
module np_page_capture #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] page_in,
   output logic      [WIDTH-1:0] page_out
);
   // the reset value and the register map assume a 16-bit word
   if (WIDTH != 16) begin : g_bad_width
      $error("np_page_capture: WIDTH must be 16");
   end

   // register only the engine may load; software has no path here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_out <= np_regs_pkg::PARTNER_NP_RST;
      end else if (load) begin
         page_out <= page_in;
      end
   end
endmodule : np_page_capture

// *** np_regs_checker.sv ***
`timescale 1ns/1ns
// ==========================================================
// port checks for the next page registers
module np_regs_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        page_sent,
   input wire logic        sent_toggle,
   input wire logic [15:0] tx_page
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus answer timing, map and data lanes
   chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no answer");
   chk_ready_once: assert property (pready |=> !pready) else $error("long ready");
   chk_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("stray ready");
   chk_err_map:
      assert property (pready |-> pslverr == !(paddr inside {12'h01C, 12'h020}))
      else $error("bad error flag");
   chk_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000) else $error("idle data");
   chk_upper_zero:
      assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half set");
   // toggle follows the sent page, word starts at its defaults
   chk_toggle_inv:
      assert property (page_sent |-> ##2 tx_page[11] == !$past(sent_toggle, 2))
      else $error("toggle wrong");
   chk_tx_reset:
      assert property ($rose(presetn) |-> tx_page == 16'h2001) else $error("bad reset word");
   cov_toggle: cover property (page_sent);
   cov_err: cover property (pready && pslverr);
   cov_ok: cover property (pready && !pslverr);
endmodule : np_regs_checker

// *** np_regs_pkg.sv ***
package np_regs_pkg;
   // ==========================================================
   // register offsets (word indices, shifted by two into byte addresses of the 32-bit APB words)
   localparam logic [11:0] LOCAL_NP_TX_OFFSET   = 12'h007;
   localparam logic [11:0] PARTNER_NP_RX_OFFSET = 12'h008;
   localparam int unsigned ADDR_WORD_SHIFT      = 2;
   localparam logic [11:0] LOCAL_NP_TX_ADDR     = LOCAL_NP_TX_OFFSET << ADDR_WORD_SHIFT;
   localparam logic [11:0] PARTNER_NP_RX_ADDR   = PARTNER_NP_RX_OFFSET << ADDR_WORD_SHIFT;

   // ==========================================================
   // field positions shared by both next page words
   localparam int unsigned NP_BIT     = 15;
   localparam int unsigned ACK_BIT    = 14;
   localparam int unsigned MP_BIT     = 13;
   localparam int unsigned ACK2_BIT   = 12;
   localparam int unsigned TOGGLE_BIT = 11;
   localparam int unsigned CODE_MSB   = 10;
   localparam int unsigned CODE_W     = 11;

   // ==========================================================
   // reset values
   localparam logic              NP_RST          = 1'b0;
   localparam logic              MP_RST          = 1'b1;
   localparam logic              ACK2_RST        = 1'b0;
   localparam logic              TOGGLE_RST      = 1'b0;
   localparam logic [CODE_W-1:0] LOCAL_CODE_RST  = 11'h001;
   localparam logic [15:0]       PARTNER_NP_RST  = 16'h0000;
endpackage : np_regs_pkg
